// file: hdl/sram_host.sv
// Host-side controller that runs reads and writes on a 16K x 4 asynchronous
// static memory, and steps it into and out of low-supply data retention.
// Assumes memory pins are one clock domain away: read data is synchronised.
`timescale 1ns/1ns
module sram_host (
  // Clock and reset
  input  wire logic                          core_clk_i,
  input  wire logic                          srst_i,
  // Request port
  input  wire logic                          req_valid_i,
  input  wire sram_host_pkg::req_t           req_i,
  output logic                               req_ready_o,
  output logic                               rd_valid_o,
  output logic [sram_host_pkg::DATA_W-1:0]   rd_data_o,
  // Retention control
  input  wire logic                          retain_req_i,
  output logic                               retain_ok_o,
  // Memory pins
  output sram_host_pkg::mem_ctl_t            mem_ctl_o,
  input  wire logic [sram_host_pkg::DATA_W-1:0] mem_data_i,
  output logic [sram_host_pkg::DATA_W-1:0]   mem_data_o,
  output logic                               mem_data_oe_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  // Registered state and its next value, paired per line; the last line holds the two synchroniser flops
  sram_host_pkg::state_t                   state_r,    state_nxt;
  logic [sram_host_pkg::CNT_W-1:0]         cnt_r,      cnt_nxt;
  sram_host_pkg::mem_ctl_t                 ctl_r,      ctl_nxt;
  logic [sram_host_pkg::DATA_W-1:0]        dout_r,     dout_nxt;
  logic                                    oe_r,       oe_nxt;
  logic                                    ready_r,    ready_nxt;
  logic                                    rvalid_r,   rvalid_nxt;
  logic [sram_host_pkg::DATA_W-1:0]        rdata_r,    rdata_nxt;
  logic                                    ret_r,      ret_nxt;
  logic [sram_host_pkg::DATA_W-1:0]        din_s1_r,   din_s2_r;

  // Counter load for a wait of n cycles; the counter runs down to zero
  function automatic logic [sram_host_pkg::CNT_W-1:0] cyc(input int n);
    int m;
    m = n - 1;
    return m[sram_host_pkg::CNT_W-1:0];
  endfunction

  // ****************************************************************
  // Read data synchroniser
  // ****************************************************************
  // Two flops before any logic reads the data pins
  always_ff @(posedge core_clk_i) begin
    din_s1_r <= mem_data_i;
    din_s2_r <= din_s1_r;
  end

  // ****************************************************************
  // Access sequencer
  // ****************************************************************
  // Next-state logic of the access sequencer
  always_comb begin
    // Hold by default; the counter runs down to zero, pulses default low
    state_nxt  = state_r;
    cnt_nxt    = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    ctl_nxt    = ctl_r;
    dout_nxt   = dout_r;
    oe_nxt     = oe_r;
    ready_nxt  = 1'b0;
    rvalid_nxt = 1'b0;
    rdata_nxt  = rdata_r;
    ret_nxt    = ret_r;
    unique case (state_r)
      // Idle: retention wins over a request; one access per grant
      sram_host_pkg::ST_IDLE: begin
        ready_nxt = 1'b1;
        if (retain_req_i) begin
          ctl_nxt.select_n = 1'b1;
          ctl_nxt.write_strobe_n = 1'b1;
          ready_nxt = 1'b0;
          cnt_nxt   = cyc(sram_host_pkg::CDR_CYC);
          state_nxt = sram_host_pkg::ST_RET_ENT;
        end else if (req_valid_i && ready_r) begin
          ready_nxt = 1'b0;
          ctl_nxt.addr = req_i.addr;
          if (req_i.write) begin
            // Outputs off before the host drives the bus
            ctl_nxt.drive_enable_n = 1'b1;
            ctl_nxt.select_n       = 1'b0;
            ctl_nxt.write_strobe_n = 1'b0;
            dout_nxt  = req_i.wdata;
            oe_nxt    = 1'b1;
            // Drive enable stays high, so the plain pulse width is enough
            cnt_nxt   = cyc(sram_host_pkg::WP_PLAIN_CYC);
            state_nxt = sram_host_pkg::ST_WR_PUL;
          end else begin
            ctl_nxt.select_n       = 1'b0;
            ctl_nxt.write_strobe_n = 1'b1;
            ctl_nxt.drive_enable_n = 1'b0;
            oe_nxt    = 1'b0;
            cnt_nxt   = cyc(sram_host_pkg::ACC_CYC + 2);
            state_nxt = sram_host_pkg::ST_RD_ACC;
          end
        end
      end
      // Read: select held through access time and two synchroniser stages
      sram_host_pkg::ST_RD_ACC: begin
        if (cnt_r == '0) begin
          rdata_nxt  = din_s2_r;
          rvalid_nxt = 1'b1;
          ctl_nxt.select_n       = 1'b1;
          ctl_nxt.drive_enable_n = 1'b1;
          cnt_nxt   = cyc(sram_host_pkg::FLOAT_CYC);
          state_nxt = sram_host_pkg::ST_RD_END;
        end
      end
      // Read end: chip released, one cycle for its drivers to float
      sram_host_pkg::ST_RD_END: begin
        if (cnt_r == '0) begin
          ready_nxt = 1'b1;
          state_nxt = sram_host_pkg::ST_IDLE;
        end
      end
      // Write pulse: select and strobe low together, host drives data
      sram_host_pkg::ST_WR_PUL: begin
        if (cnt_r == '0) begin
          ctl_nxt.write_strobe_n = 1'b1;
          ctl_nxt.select_n       = 1'b1;
          cnt_nxt   = cyc(sram_host_pkg::WR_CYC);
          state_nxt = sram_host_pkg::ST_WR_REC;
        end
      end
      // Recovery: data held one cycle past the strobe rise
      sram_host_pkg::ST_WR_REC: begin
        if (cnt_r == '0) begin
          oe_nxt    = 1'b0;
          ready_nxt = 1'b1;
          state_nxt = sram_host_pkg::ST_IDLE;
        end
      end
      // Retention entry: chip deselected before the supply may drop
      sram_host_pkg::ST_RET_ENT: begin
        if (cnt_r == '0) begin
          ret_nxt   = 1'b1;
          state_nxt = sram_host_pkg::ST_RET;
        end
      end
      // Retention: wait for the request to go away
      sram_host_pkg::ST_RET: begin
        if (!retain_req_i) begin
          ret_nxt   = 1'b0;
          cnt_nxt   = cyc(sram_host_pkg::RC_CYC);
          state_nxt = sram_host_pkg::ST_WAKE;
        end
      end
      // Wake: one read cycle time before the first access
      sram_host_pkg::ST_WAKE: begin
        if (cnt_r == '0) begin
          ready_nxt = 1'b1;
          state_nxt = sram_host_pkg::ST_IDLE;
        end
      end
      // Illegal codes return to idle
      default: begin
        state_nxt = sram_host_pkg::ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Sequencer registers
  // ****************************************************************
  // Register the sequencer; pins idle deselected and floating
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_r  <= sram_host_pkg::ST_IDLE;
      cnt_r    <= '0;
      ctl_r    <= '{select_n: 1'b1, write_strobe_n: 1'b1, drive_enable_n: 1'b1, addr: '0};
      dout_r   <= '0;
      oe_r     <= 1'b0;
      ready_r  <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      ret_r    <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      ctl_r    <= ctl_nxt;
      dout_r   <= dout_nxt;
      oe_r     <= oe_nxt;
      ready_r  <= ready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      ret_r    <= ret_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every output comes straight from a register
  assign req_ready_o   = ready_r;
  assign rd_valid_o    = rvalid_r;
  assign rd_data_o     = rdata_r;
  assign retain_ok_o   = ret_r;
  assign mem_ctl_o     = ctl_r;
  assign mem_data_o    = dout_r;
  assign mem_data_oe_o = oe_r;

endmodule // sram_host

// file: hdl/sram_host_pkg.sv
// Package for the host controller of a 16K x 4 asynchronous static memory.
// Assumes a single 50 MHz core clock; all timing counts derive from it.
package sram_host_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int ADDR_W = 14;
  localparam int DATA_W = 4;

  // ****************************************************************
  // Timing, in ns as printed, then in cycles
  // ****************************************************************
  localparam int CLK_PERIOD_NS                   = 20;
  localparam int WRITE_PULSE_WIDTH_NS            = 14;
  localparam int STROBE_TO_FLOAT_DELAY_NS        = 5;
  localparam int DATA_VALID_BEFORE_WRITE_END_NS  = 10;
  localparam int WRITE_RECOVERY_TIME_NS          = 0;
  localparam int DESELECT_TO_RETENTION_TIME_NS   = 0;
  localparam int READ_CYCLE_NS                   = 15;
  localparam int READ_ACCESS_NS                  = 15;
  localparam int OUT_FLOAT_NS                    = 7;

  // Least times round up, never below one cycle
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int WP_PLAIN_CYC  = min_cycles(WRITE_PULSE_WIDTH_NS);
  localparam int WP_DRIVEN_CYC = min_cycles((WRITE_PULSE_WIDTH_NS >
                                 STROBE_TO_FLOAT_DELAY_NS + DATA_VALID_BEFORE_WRITE_END_NS) ?
                                 WRITE_PULSE_WIDTH_NS :
                                 STROBE_TO_FLOAT_DELAY_NS + DATA_VALID_BEFORE_WRITE_END_NS);
  localparam int WR_CYC        = min_cycles(WRITE_RECOVERY_TIME_NS);
  localparam int CDR_CYC       = min_cycles(DESELECT_TO_RETENTION_TIME_NS);
  localparam int RC_CYC        = min_cycles(READ_CYCLE_NS);
  localparam int ACC_CYC       = min_cycles(READ_ACCESS_NS);
  localparam int FLOAT_CYC     = min_cycles(OUT_FLOAT_NS);
  localparam int CNT_W         = 4;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_t;

  typedef struct packed {
    logic              select_n;
    logic              write_strobe_n;
    logic              drive_enable_n;
    logic [ADDR_W-1:0] addr;
  } mem_ctl_t;

  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_RD_ACC  = 8'h02,
    ST_RD_END  = 8'h04,
    ST_WR_PUL  = 8'h08,
    ST_WR_REC  = 8'h10,
    ST_RET_ENT = 8'h20,
    ST_RET     = 8'h40,
    ST_WAKE    = 8'h80
  } state_t;

endpackage

// file: verification/sram_host_properties.sv
// Checker for the memory pins of sram_host.
// Assumes it is bound to sram_host and sees only its ports.
`timescale 1ns/1ns
module sram_host_properties (
  // Clock, reset and requests
  input wire logic                         core_clk_i,
  input wire logic                         srst_i,
  input wire logic                         req_valid_i,
  input wire sram_host_pkg::req_t          req_i,
  input wire logic                         req_ready_o,
  input wire logic                         rd_valid_o,
  input wire logic [3:0]                   rd_data_o,
  input wire logic                         retain_req_i,
  input wire logic                         retain_ok_o,
  // Memory pins
  input wire sram_host_pkg::mem_ctl_t      mem_ctl_o,
  input wire logic [3:0]                   mem_data_i,
  input wire logic [3:0]                   mem_data_o,
  input wire logic                         mem_data_oe_o
);
  // ********************
  // Pin aliases
  // ********************
  wire sel_n = mem_ctl_o.select_n;
  wire we_n  = mem_ctl_o.write_strobe_n;
  wire de_n  = mem_ctl_o.drive_enable_n;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // Accepted request of one kind
  sequence take_s(logic w);
    req_valid_i && req_ready_o && !retain_req_i && req_i.write == w;
  endsequence
  // Read pin steps, then the answer with the chip released
  sequence rd_pins_s;
    (!sel_n && !de_n && we_n)[*3] ##1 (rd_valid_o && sel_n);
  endsequence
  // Write pin steps, then the bus handed back
  sequence wr_pins_s;
    (!sel_n && !we_n && mem_data_oe_o) ##1 (sel_n && we_n && mem_data_oe_o) ##1 (!mem_data_oe_o && req_ready_o);
  endsequence
  a_read_walk: assert property (take_s(1'h0) |=> rd_pins_s) else $error("read pin sequence wrong");
  a_write_walk: assert property (take_s(1'h1) |=> wr_pins_s) else $error("write pin sequence wrong");
  a_write_data: assert property (take_s(1'h1) |=> mem_data_o == $past(req_i.wdata)) else $error("write data wrong");
  a_addr_quiet: assert property ($changed(mem_ctl_o.addr) |-> $past(sel_n) || $past(we_n)) else $error("address moved in write");
  a_read_no_strobe: assert property (!de_n |-> we_n && !mem_data_oe_o) else $error("strobe or drive in read");
  a_strobe_plain: assert property (!we_n |-> de_n && mem_data_oe_o) else $error("write with output enabled");
  a_recovery_hold: assert property ($rose(we_n) |-> mem_data_oe_o && sel_n) else $error("write end wrong");
  a_retain_desel: assert property (retain_ok_o |-> sel_n && $past(sel_n)) else $error("retention while selected");
  a_wake_wait: assert property ($fell(retain_ok_o) |-> !req_ready_o) else $error("ready too soon after wake");
endmodule // sram_host_properties

// file: verification/sram_host_tb.sv
// Self-checking bench for sram_host with a memory model on its pins.
// Assumes the checker sram_host_properties is compiled alongside.
`timescale 1ns/1ns
module sram_host_tb;
  logic                    core_clk_i   = 1'h0;
  logic                    srst_i       = 1'h1;
  logic                    req_valid_i  = 1'h0;
  logic                    retain_req_i = 1'h0;
  sram_host_pkg::req_t     req_i        = '0;
  logic                    req_ready_o, rd_valid_o, retain_ok_o, mem_data_oe_o;
  logic [3:0]              rd_data_o, mem_data_i, mem_data_o;
  sram_host_pkg::mem_ctl_t mem_ctl_o;
  int                      n_fail = 0;
  int                      samples_checked = 0;
  int                      cycles = 0;
  // ********************
  // Clock and instances
  // ********************
  always #10 core_clk_i = ~core_clk_i;
  sram_host sram_host_inst (.core_clk_i(core_clk_i), .srst_i(srst_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .retain_req_i(retain_req_i),
    .retain_ok_o(retain_ok_o), .mem_ctl_o(mem_ctl_o), .mem_data_i(mem_data_i), .mem_data_o(mem_data_o),
    .mem_data_oe_o(mem_data_oe_o));
  sram_mem_model sram_mem_model_inst (.ctl_i(mem_ctl_o), .host_data_i(mem_data_o), .host_oe_i(mem_data_oe_o),
    .pin_o(mem_data_i));
  // Compare and count
  task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask
  // One request, held until the edge that takes it
  task automatic op(input logic w, input logic [13:0] a, input logic [3:0] d);
    for (int n = 0; n < 20 && req_ready_o !== 1'h1; n++) tick();
    req_i = '{w, a, d};
    req_valid_i = 1'h1;
    tick();
    req_valid_i = 1'h0;
  endtask
  task automatic rd(input logic [13:0] a, input logic [3:0] exp);
    op(1'h0, a, 4'h0);
    for (int n = 0; n < 10 && rd_valid_o !== 1'h1; n++) tick();
    chk("rd_valid_o", 4'h1, {3'h0, rd_valid_o});
    chk("rd_data_o", exp, rd_data_o);
  endtask
  // Back-to-back writes at both address ends, then read back
  task automatic test_store();
    op(1'h1, 14'h0000, 4'h5);
    op(1'h1, 14'h3FFF, 4'hA);
    rd(14'h0000, 4'h5);
    rd(14'h3FFF, 4'hA);
    $display("test_store done");
  endtask
  // A request while busy must be dropped
  task automatic test_refused();
    op(1'h1, 14'h0010, 4'h3);
    tick();
    req_i = '{1'h1, 14'h0010, 4'hC};
    req_valid_i = 1'h1;
    tick();
    req_valid_i = 1'h0;
    rd(14'h0010, 4'h3);
    $display("test_refused done");
  endtask
  // Retention wins over a request, then waking waits before access
  task automatic test_retain();
    for (int n = 0; n < 20 && req_ready_o !== 1'h1; n++) tick();
    retain_req_i = 1'h1;
    req_i = '{1'h1, 14'h0000, 4'h9};
    req_valid_i = 1'h1;
    tick();
    req_valid_i = 1'h0;
    for (int n = 0; n < 10 && retain_ok_o !== 1'h1; n++) tick();
    chk("retain_ok_o", 4'h1, {3'h0, retain_ok_o});
    chk("select_n", 4'h1, {3'h0, mem_ctl_o.select_n});
    retain_req_i = 1'h0;
    tick();
    chk("req_ready_o", 4'h0, {3'h0, req_ready_o});
    rd(14'h0000, 4'h5);
    $display("test_retain done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      $display("[FAIL] cycles expected below 3000 seen %0d", cycles);
      report_and_stop();
    end
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk_i);
    #1 srst_i = 1'h0;
    test_store();
    test_refused();
    test_retain();
    report_and_stop();
  end
endmodule // sram_host_tb
bind sram_host sram_host_properties sram_host_properties_inst (.core_clk_i(core_clk_i), .srst_i(srst_i),
  .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o),
  .rd_data_o(rd_data_o), .retain_req_i(retain_req_i), .retain_ok_o(retain_ok_o), .mem_ctl_o(mem_ctl_o),
  .mem_data_i(mem_data_i), .mem_data_o(mem_data_o), .mem_data_oe_o(mem_data_oe_o));

// file: verification/sram_mem_model.sv
// Behavioural 16K x 4 asynchronous static memory at the pins.
// Assumes the host splits the data pins into data, drive and enable.
`timescale 1ns/1ns
module sram_mem_model (
  // Control pins and host drive
  input  wire sram_host_pkg::mem_ctl_t ctl_i,
  input  wire logic [3:0]              host_data_i,
  input  wire logic                    host_oe_i,
  // Resolved data pin level
  output logic [3:0]                   pin_o
);
  logic [3:0] mem [16384];
  logic [3:0] last_r = 4'h0;
  logic       drive;
  // Drives only in a read; floats when deselected or written
  assign drive = !ctl_i.select_n && ctl_i.write_strobe_n && !ctl_i.drive_enable_n;
  // Pin level; a floated pin shows the inverse of its last level
  always @* begin
    if (host_oe_i) pin_o = host_data_i;
    else if (drive) pin_o = mem[ctl_i.addr];
    else pin_o = ~last_r;
  end
  always @* if (host_oe_i || drive) last_r = pin_o;
  // Store while select and strobe overlap low
  always @* if (!ctl_i.select_n && !ctl_i.write_strobe_n) mem[ctl_i.addr] = pin_o;
endmodule // sram_mem_model
